/* link_tuning_regs.svh */
`ifndef LINK_TUNING_REGS_SVH
`define LINK_TUNING_REGS_SVH
// Register offsets (byte addresses in configuration space)
`define OFS_LIFETIME   8'hd0
`define OFS_RECOVERY   8'hd4
`define OFS_PD_CMD     8'hd8
`define OFS_PD_WORD    8'hdc
`define OFS_RSV_LO     8'he0
`define OFS_RSV_HI     8'hec
`define OFS_MSI_HDR    8'hf0
// Field positions
`define L0S_LIFE_MSB   9
`define L1_LIFE_LSB    16
`define CDR_MSB        7
`define L0S_EXIT_LSB   8
`define L0S_EXIT_MSB   14
`define POL_BIT        15
`define L1_EXIT_LSB    16
`define L1_EXIT_MSB    22
`define WAIT_LSB       24
`define PD_ADDR_LSB    18
`define PD_ADDR_MSB    23
`define PD_FLAG_BIT    31
// Reset values and fixed identifiers
`define CDR_RST        8'h54
`define L0S_EXIT_RST   7'h02
`define L1_EXIT_RST    7'h19
`define WAIT_RST       8'h00
`define PD_CAP_ID      8'h03
`define PD_NEXT_PTR    8'hf0
`define MSI_CAP_ID     8'h05
`define MSI_NEXT_PTR   8'h00
// Timing and mapping
`define WAIT_SPLIT     8'h80
`define WAIT_BASE_MS   9'h080
`define PD_AREA_OFS    8'h40
`define FTS_SYMBOLS    3'h4
`endif

/* link_tuning_pkg.sv */
package link_tuning_pkg;
  // One configuration access from the host
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  // One request towards the serial EEPROM engine
  typedef struct packed {
    logic        start;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } eeprom_req_t;

  typedef enum logic [1:0] {
    PD_IDLE  = 2'b00,
    PD_READ  = 2'b01,
    PD_WRITE = 2'b10
  } pd_state_t;
endpackage

/* wait_period_decode.sv */
`timescale 1ns/10ps
`include "link_tuning_regs.svh"
// Turns the waiting-period code into milliseconds
module wait_period_decode
  import link_tuning_pkg::*;
(
  input  wire logic [7:0] code_i,
  output logic      [8:0] ms_o
);
  // Low half adds the 128 ms base, high half strips the split bit
  always_comb
  begin
    if (code_i < `WAIT_SPLIT)
      ms_o = `WAIT_BASE_MS + {1'b0, code_i};
    else
      ms_o = {1'b0, code_i - `WAIT_SPLIT};
  end
endmodule

/* fts_counter.sv */
`timescale 1ns/10ps
`include "link_tuning_regs.svh"
// Counts symbols into ordered sets: one comma then three K28.1
module fts_counter
  import link_tuning_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       en_i,
  input  wire logic       clear_i,
  input  wire logic       sym_valid_i,
  input  wire logic       sym_comma_i,
  input  wire logic       sym_k281_i,
  output logic      [7:0] sets_o
);
  logic [2:0] pos_q;

  // Sequence tracker; a stray symbol restarts the set so broken sets never count
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pos_q  <= 3'h0;
      sets_o <= 8'h00;
    end
    else if (en_i)
    begin
      if (clear_i)
      begin
        pos_q  <= 3'h0;
        sets_o <= 8'h00;
      end
      else if (sym_valid_i)
      begin
        if (sym_comma_i)
          pos_q <= 3'h1;
        else if (sym_k281_i && pos_q != 3'h0)
        begin
          if (pos_q == `FTS_SYMBOLS - 3'h1)
          begin
            pos_q <= 3'h0;
            if (sets_o != 8'hff)
              sets_o <= sets_o + 8'h01;
          end
          else
            pos_q <= pos_q + 3'h1;
        end
        else
          pos_q <= 3'h0;
      end
    end
  end
endmodule

/* link_tuning_cfg.sv */
`timescale 1ns/10ps
`include "link_tuning_regs.svh"
// Operation
// - Clock-recovery FTS count field, reset 54h
// - FTS set is comma plus three K28.1
// - L0s exit latency bits 14:8, reset 2
// - L1 exit latency bits 22:16, reset 19h
// - Polarity bit inverts receive pair
// - Waiting period code decoded to milliseconds
// - Product data capability id 03h
// - Product data next pointer F0h
// - Flag 0 write reads EEPROM, sets flag
// - Flag 1 write writes EEPROM, clears flag
// - Data LSB is addressed byte, +0x40
// - Byte enables honoured on data register
// - Interrupt capability id 05h
// - Interrupt next pointer 00h, list ends
module link_tuning_cfg
  import link_tuning_pkg::*;
(
  input  wire logic                        REF_CLK_I,
  input  wire logic                        RST_B_I,
  input  wire logic                        CLK_EN_I,
  input  wire link_tuning_pkg::cfg_req_t   CFG_REQ_I,
  output logic      [31:0]                 CFG_RDATA_O,
  output logic                             CFG_RVALID_O,
  output link_tuning_pkg::eeprom_req_t     EE_REQ_O,
  input  wire logic                        EE_DONE_I,
  input  wire logic [31:0]                 EE_RDATA_I,
  input  wire logic                        RX_P_I,
  input  wire logic                        RX_N_I,
  output logic                             RX_P_O,
  output logic                             RX_N_O,
  input  wire logic                        SYM_VALID_I,
  input  wire logic                        SYM_COMMA_I,
  input  wire logic                        SYM_K281_I,
  input  wire logic                        FTS_CLEAR_I,
  output logic      [7:0]                  FTS_SETS_O,
  output logic                             CDR_DONE_O,
  output logic      [9:0]                  L0S_LIFE_O,
  output logic      [15:0]                 L1_LIFE_O,
  output logic      [7:0]                  CDR_SETS_O,
  output logic      [6:0]                  L0S_EXIT_O,
  output logic      [6:0]                  L1_EXIT_O,
  output logic      [8:0]                  L1_WAIT_MS_O
);
  import link_tuning_pkg::*;

  logic [9:0]  l0s_life_q;
  logic [15:0] l1_life_q;
  logic [7:0]  cdr_q;
  logic [6:0]  l0s_exit_q;
  logic        pol_q;
  logic [6:0]  l1_exit_q;
  logic [7:0]  wait_q;
  logic [5:0]  pd_addr_q;
  logic        pd_flag_q;
  logic [31:0] pd_data_q;
  pd_state_t   pd_state_q;
  logic [8:0]  wait_ms;
  logic [7:0]  fts_sets;
  logic [31:0] rdata_d;
  logic        wr_lifetime;
  logic        wr_recovery;
  logic        wr_pd_cmd;
  logic        wr_pd_word;
  logic        pd_busy;

  // Merge write data into old value under byte enables
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  // Write strobes per register
  assign wr_lifetime = CFG_REQ_I.wr && CFG_REQ_I.addr == `OFS_LIFETIME;
  assign wr_recovery = CFG_REQ_I.wr && CFG_REQ_I.addr == `OFS_RECOVERY;
  assign wr_pd_cmd   = CFG_REQ_I.wr && CFG_REQ_I.addr == `OFS_PD_CMD;
  assign wr_pd_word  = CFG_REQ_I.wr && CFG_REQ_I.addr == `OFS_PD_WORD;
  assign pd_busy     = pd_state_q != PD_IDLE;

  // Lifetime timers; bits 15:10 have no storage
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      l0s_life_q <= 10'h000;
      l1_life_q  <= 16'h0000;
    end
    else if (CLK_EN_I && wr_lifetime)
    begin
      if (CFG_REQ_I.be[0])
        l0s_life_q[7:0] <= CFG_REQ_I.wdata[7:0];
      if (CFG_REQ_I.be[1])
        l0s_life_q[9:8] <= CFG_REQ_I.wdata[`L0S_LIFE_MSB:8];
      if (CFG_REQ_I.be[2])
        l1_life_q[7:0] <= CFG_REQ_I.wdata[23:16];
      if (CFG_REQ_I.be[3])
        l1_life_q[15:8] <= CFG_REQ_I.wdata[31:24];
    end
  end

  // Recovery, exit latency, polarity and waiting period
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      cdr_q      <= `CDR_RST;
      l0s_exit_q <= `L0S_EXIT_RST;
      pol_q      <= 1'b0;
      l1_exit_q  <= `L1_EXIT_RST;
      wait_q     <= `WAIT_RST;
    end
    else if (CLK_EN_I && wr_recovery)
    begin
      if (CFG_REQ_I.be[0])
        cdr_q <= CFG_REQ_I.wdata[`CDR_MSB:0];
      if (CFG_REQ_I.be[1])
      begin
        l0s_exit_q <= CFG_REQ_I.wdata[`L0S_EXIT_MSB:`L0S_EXIT_LSB];
        pol_q      <= CFG_REQ_I.wdata[`POL_BIT];
      end
      if (CFG_REQ_I.be[2])
        l1_exit_q <= CFG_REQ_I.wdata[`L1_EXIT_MSB:`L1_EXIT_LSB];
      if (CFG_REQ_I.be[3])
        wait_q <= CFG_REQ_I.wdata[31:`WAIT_LSB];
    end
  end

  // Product data command; a new command while busy is dropped, since the host must poll first
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      pd_addr_q  <= 6'h00;
      pd_flag_q  <= 1'b0;
      pd_state_q <= PD_IDLE;
      EE_REQ_O   <= '0;
    end
    else if (CLK_EN_I)
    begin
      EE_REQ_O.start <= 1'b0;
      if (pd_busy && EE_DONE_I)
      begin
        pd_flag_q  <= (pd_state_q == PD_READ);
        pd_state_q <= PD_IDLE;
      end
      else if (!pd_busy && wr_pd_cmd && CFG_REQ_I.be[3])
      begin
        if (CFG_REQ_I.be[2])
          pd_addr_q <= CFG_REQ_I.wdata[`PD_ADDR_MSB:`PD_ADDR_LSB];
        pd_flag_q       <= CFG_REQ_I.wdata[`PD_FLAG_BIT];
        pd_state_q      <= CFG_REQ_I.wdata[`PD_FLAG_BIT] ? PD_WRITE : PD_READ;
        EE_REQ_O.start  <= 1'b1;
        EE_REQ_O.write  <= CFG_REQ_I.wdata[`PD_FLAG_BIT];
        EE_REQ_O.addr   <= `PD_AREA_OFS + {2'h0, (CFG_REQ_I.be[2] ?
                           CFG_REQ_I.wdata[`PD_ADDR_MSB:`PD_ADDR_LSB] : pd_addr_q)};
        EE_REQ_O.wdata  <= pd_data_q;
      end
      else if (!pd_busy && wr_pd_cmd && CFG_REQ_I.be[2])
        pd_addr_q <= CFG_REQ_I.wdata[`PD_ADDR_MSB:`PD_ADDR_LSB];
    end
  end

  // Product data word: read completion loads it, host writes obey byte enables
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      pd_data_q <= 32'h00000000;
    else if (CLK_EN_I)
    begin
      if (pd_state_q == PD_READ && EE_DONE_I)
        pd_data_q <= EE_RDATA_I;
      else if (wr_pd_word)
        pd_data_q <= merge_be(pd_data_q, CFG_REQ_I.wdata, CFG_REQ_I.be);
    end
  end

  // Read mux; reserved words and bits read zero
  always_comb
  begin
    rdata_d = 32'h00000000;
    unique case (CFG_REQ_I.addr)
      `OFS_LIFETIME:
        rdata_d = {l1_life_q, 6'h00, l0s_life_q};
      `OFS_RECOVERY:
        rdata_d = {wait_q, 1'b0, l1_exit_q, pol_q, l0s_exit_q, cdr_q};
      `OFS_PD_CMD:
        rdata_d = {pd_flag_q, 7'h00, pd_addr_q, 2'h0, `PD_NEXT_PTR, `PD_CAP_ID};
      `OFS_PD_WORD:
        rdata_d = pd_data_q;
      `OFS_MSI_HDR:
        rdata_d = {16'h0000, `MSI_NEXT_PTR, `MSI_CAP_ID};
      default:
        rdata_d = 32'h00000000;
    endcase
  end

  // Read data is masked by byte enables and registered
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      CFG_RDATA_O  <= 32'h00000000;
      CFG_RVALID_O <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      CFG_RVALID_O <= CFG_REQ_I.rd;
      if (CFG_REQ_I.rd)
        CFG_RDATA_O <= merge_be(32'h00000000, rdata_d, CFG_REQ_I.be);
    end
  end

  // Receive pair swap; registered, so it adds one cycle of latency
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      RX_P_O <= 1'b0;
      RX_N_O <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      RX_P_O <= pol_q ? RX_N_I : RX_P_I;
      RX_N_O <= pol_q ? RX_P_I : RX_N_I;
    end
  end

  wait_period_decode u_wait
  (
    .code_i (wait_q),
    .ms_o   (wait_ms)
  );

  fts_counter u_fts
  (
    .clk_i       (REF_CLK_I),
    .rst_b_i     (RST_B_I),
    .en_i        (CLK_EN_I),
    .clear_i     (FTS_CLEAR_I),
    .sym_valid_i (SYM_VALID_I),
    .sym_comma_i (SYM_COMMA_I),
    .sym_k281_i  (SYM_K281_I),
    .sets_o      (fts_sets)
  );

  // Field outputs to the link state machine
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      L0S_LIFE_O   <= 10'h000;
      L1_LIFE_O    <= 16'h0000;
      CDR_SETS_O   <= `CDR_RST;
      L0S_EXIT_O   <= `L0S_EXIT_RST;
      L1_EXIT_O    <= `L1_EXIT_RST;
      L1_WAIT_MS_O <= `WAIT_BASE_MS;
      FTS_SETS_O   <= 8'h00;
      CDR_DONE_O   <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      L0S_LIFE_O   <= l0s_life_q;
      L1_LIFE_O    <= l1_life_q;
      CDR_SETS_O   <= cdr_q;
      L0S_EXIT_O   <= l0s_exit_q;
      L1_EXIT_O    <= l1_exit_q;
      L1_WAIT_MS_O <= wait_ms;
      FTS_SETS_O   <= fts_sets;
      CDR_DONE_O   <= fts_sets >= cdr_q;
    end
  end

  // Checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);

  pd_read_start_a: assert property (CLK_EN_I && !pd_busy && wr_pd_cmd && CFG_REQ_I.be[3]
    && !CFG_REQ_I.wdata[31] |=> !pd_flag_q && pd_state_q == PD_READ)
    else $error("read command did not clear flag");
  pd_read_done_a: assert property (CLK_EN_I && pd_state_q == PD_READ && EE_DONE_I
    |=> pd_flag_q && pd_data_q == $past(EE_RDATA_I))
    else $error("read completion wrong");
  pd_write_done_a: assert property (CLK_EN_I && pd_state_q == PD_WRITE && EE_DONE_I |=> !pd_flag_q)
    else $error("write completion flag wrong");
  pd_flag_hold_a: assert property (pd_busy && !EE_DONE_I |=> $stable(pd_flag_q))
    else $error("flag moved while busy");
  ee_addr_map_a: assert property (EE_REQ_O.start |-> EE_REQ_O.addr == `PD_AREA_OFS + {2'h0, pd_addr_q})
    else $error("eeprom address offset wrong");
  cap_read_a: assert property (CLK_EN_I && CFG_REQ_I.rd && CFG_REQ_I.addr == `OFS_PD_CMD
    && CFG_REQ_I.be[1:0] == 2'b11 |=> CFG_RDATA_O[15:0] == 16'hf003)
    else $error("product data header wrong");
  msi_read_a: assert property (CLK_EN_I && CFG_REQ_I.rd && CFG_REQ_I.addr == `OFS_MSI_HDR
    && CFG_REQ_I.be[1:0] == 2'b11 |=> CFG_RDATA_O[15:0] == 16'h0005)
    else $error("interrupt header wrong");
  reserved_zero_a: assert property (CLK_EN_I && CFG_REQ_I.rd && CFG_REQ_I.addr >= `OFS_RSV_LO
    && CFG_REQ_I.addr <= `OFS_RSV_HI |=> CFG_RDATA_O == 32'h00000000)
    else $error("reserved register not zero");
  pol_swap_a: assert property (CLK_EN_I && pol_q |=> RX_P_O == $past(RX_N_I))
    else $error("polarity not inverted");
  wait_decode_a: assert property (wait_q == 8'h80 |-> wait_ms == 9'h000)
    else $error("waiting period decode wrong");

  pd_read_c: cover property (pd_state_q == PD_READ ##[1:20] pd_flag_q);
  pd_write_c: cover property (pd_state_q == PD_WRITE ##[1:20] !pd_busy);
  pol_on_c: cover property (pol_q);
  cdr_done_c: cover property (CDR_DONE_O);
endmodule

/* eeprom_model.sv */
`timescale 1ns/10ps
// Behavioural serial EEPROM engine: answers each start after a fixed delay
module eeprom_model
  import link_tuning_pkg::*;
#(
  parameter int DELAY = 6
)
(
  input  wire logic                         clk_i,
  input  wire logic                         rst_b_i,
  input  wire link_tuning_pkg::eeprom_req_t req_i,
  output logic                              done_o,
  output logic [31:0]                       rdata_o,
  output int                                starts_o
);
  logic [31:0] mem [0:255];
  int          cnt_q;

  // Read data means something only with done; otherwise it toggles so stale use shows up
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= 0;
      done_o <= 1'b0;
      rdata_o <= 32'h0;
      starts_o <= 0;
    end
    else
    begin
      done_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i.start)
      begin
        cnt_q <= DELAY;
        starts_o <= starts_o + 1;
      end
      else if (cnt_q == 1)
      begin
        cnt_q <= 0;
        done_o <= 1'b1;
        if (req_i.write)
          mem[req_i.addr] <= req_i.wdata;
        else
          rdata_o <= mem[req_i.addr];
      end
      else if (cnt_q > 1)
        cnt_q <= cnt_q - 1;
    end
  end
endmodule

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  import link_tuning_pkg::*;
  logic        ref_clk;
  logic        rst_b;
  logic        clk_en;
  cfg_req_t    req;
  logic [31:0] rdata;
  logic        rvalid;
  eeprom_req_t ee_req;
  logic        ee_done;
  logic [31:0] ee_rdata;
  logic        rx_p, rx_n, rx_p_o, rx_n_o;
  logic        sym_v, sym_c, sym_k, fts_clr, cdr_done;
  logic [7:0]  fts_sets, cdr_sets;
  logic [9:0]  l0s_life;
  logic [15:0] l1_life;
  logic [6:0]  l0s_exit, l1_exit;
  logic [8:0]  wait_ms;
  logic [31:0] v;
  logic [7:0]  codes [6] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'h81, 8'hff};
  int          mismatches, n_tests, ee_starts;

  link_tuning_cfg i_dut (.REF_CLK_I(ref_clk), .RST_B_I(rst_b), .CLK_EN_I(clk_en), .CFG_REQ_I(req),
    .CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid), .EE_REQ_O(ee_req), .EE_DONE_I(ee_done),
    .EE_RDATA_I(ee_rdata), .RX_P_I(rx_p), .RX_N_I(rx_n), .RX_P_O(rx_p_o), .RX_N_O(rx_n_o),
    .SYM_VALID_I(sym_v), .SYM_COMMA_I(sym_c), .SYM_K281_I(sym_k), .FTS_CLEAR_I(fts_clr),
    .FTS_SETS_O(fts_sets), .CDR_DONE_O(cdr_done), .L0S_LIFE_O(l0s_life), .L1_LIFE_O(l1_life),
    .CDR_SETS_O(cdr_sets), .L0S_EXIT_O(l0s_exit), .L1_EXIT_O(l1_exit), .L1_WAIT_MS_O(wait_ms));

  eeprom_model i_ee (.clk_i(ref_clk), .rst_b_i(rst_b), .req_i(ee_req), .done_o(ee_done),
    .rdata_o(ee_rdata), .starts_o(ee_starts));

  // 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle configuration write; no answer comes back
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, be: b, wdata: d};
    @(posedge ref_clk);
    req <= '0;
  endtask

  // Read: valid and data are sampled just after the edge that takes the request
  task automatic rd(input logic [7:0] a, input logic [3:0] b, output logic [31:0] d);
    @(posedge ref_clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, be: b, wdata: 32'h0};
    @(posedge ref_clk);
    req <= '0;
    #1;
    check({31'h0, rvalid}, 32'h1);
    d = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [3:0] b, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, b, d);
    check(d, exp);
  endtask

  // Host side waits for the operation flag to turn, bounded
  task automatic poll(input logic want);
    logic [31:0] d;
    int i;
    for (i = 0; i < 100; i++)
    begin
      rd(8'hd8, 4'hf, d);
      if (d[31] === want)
        break;
    end
    if (i == 100)
    begin
      mismatches++;
      $display("ERROR %0t: operation flag never turned", $time);
      complete_run();
    end
  endtask

  // Comma followed by a number of K28.1 symbols
  task automatic send_set(input int ks);
    @(posedge ref_clk);
    sym_v <= 1'b1;
    sym_c <= 1'b1;
    sym_k <= 1'b0;
    repeat (ks)
    begin
      @(posedge ref_clk);
      sym_c <= 1'b0;
      sym_k <= 1'b1;
    end
    @(posedge ref_clk);
    sym_v <= 1'b0;
    sym_k <= 1'b0;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    $display("ERROR %0t: run timed out", $time);
    complete_run();
  end

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    req = '0;
    {rx_p, rx_n, sym_v, sym_c, sym_k, fts_clr} = 6'b100000;
    mismatches = 0;
    n_tests = 0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    check({9'h0, l1_exit, 1'b0, l0s_exit, cdr_sets}, 32'h0019_0254);
    check({23'h0, wait_ms}, 32'h80);
    rchk(8'hd4, 4'hf, 32'h0019_0254);
    rchk(8'hd4, 4'h1, 32'h0000_0054);
    rchk(8'hd8, 4'hf, 32'h0000_f003);
    rchk(8'hf0, 4'h3, 32'h0000_0005);
    wr(8'hd0, 4'hf, 32'hffff_ffff);
    rchk(8'hd0, 4'hf, 32'hffff_03ff);
    check({l1_life, 6'h00, l0s_life}, 32'hffff_03ff);
    wr(8'hd8, 4'h3, 32'hffff_ffff);
    rchk(8'hd8, 4'hf, 32'h0000_f003);
    wr(8'hf0, 4'h3, 32'hffff_ffff);
    rchk(8'hf0, 4'h3, 32'h0000_0005);
    for (int a = 8'he0; a <= 8'hec; a += 4)
    begin
      wr(a[7:0], 4'hf, 32'hffff_ffff);
      rchk(a[7:0], 4'hf, 32'h0);
    end
    rchk(8'h10, 4'hf, 32'h0);
    wr(8'hd4, 4'h7, 32'h00ff_ffff);
    rchk(8'hd4, 4'hf, 32'h007f_ffff);
    check({rx_p_o, rx_n_o, l1_exit, l0s_exit, cdr_sets}, {2'b01, 22'h3fffff});
    wr(8'hd4, 4'h2, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1;
    check({30'h0, rx_p_o, rx_n_o}, 32'h2);
    foreach (codes[i])
    begin
      wr(8'hd4, 4'h8, {codes[i], 24'h0});
      repeat (3) @(posedge ref_clk);
      #1;
      check({23'h0, wait_ms}, codes[i] < 8'h80 ? 32'h80 + codes[i] : codes[i] - 32'h80);
    end
    // Only complete ordered sets count towards clock recovery
    wr(8'hd4, 4'h1, 32'h2);
    // A write while the clock enable is low must leave the field alone
    clk_en <= 1'b0;
    wr(8'hd4, 4'h1, 32'h33);
    clk_en <= 1'b1;
    rchk(8'hd4, 4'h1, 32'h2);
    fts_clr <= 1'b1;
    @(posedge ref_clk);
    fts_clr <= 1'b0;
    send_set(2);
    send_set(3);
    repeat (3) @(posedge ref_clk);
    #1;
    check({23'h0, cdr_done, fts_sets}, 32'h001);
    send_set(3);
    repeat (3) @(posedge ref_clk);
    #1;
    check({23'h0, cdr_done, fts_sets}, 32'h102);
    wr(8'hdc, 4'hf, 32'h1122_3344);
    wr(8'hdc, 4'h5, 32'haabb_ccdd);
    rchk(8'hdc, 4'h6, 32'h00bb_3300);
    wr(8'hd8, 4'hc, {1'b1, 7'h0, 6'h2a, 18'h0});
    poll(1'b0);
    check(i_ee.mem[8'h6a], 32'h11bb_33dd);
    wr(8'hdc, 4'hf, 32'h0);
    wr(8'hd8, 4'hc, {1'b0, 7'h0, 6'h2a, 18'h0});
    wr(8'hd8, 4'hc, {1'b1, 7'h0, 6'h15, 18'h0});
    poll(1'b1);
    rchk(8'hdc, 4'hf, 32'h11bb_33dd);
    rchk(8'hd8, 4'hf, 32'h80a8_f003);
    check(ee_starts, 32'h2);
    complete_run();
  end
endmodule
